// >>> pkg/brs_regs.svh
// Constants of the bridge reset sequencer: register offsets, field
// positions, reset values and timing counts.
// Assumes the core clock runs at 125 MHz.
`ifndef BRS_REGS_SVH
`define BRS_REGS_SVH

`define BRS_CLK_PERIOD_NS      8
`define BRS_POR_DELAY_US       10
`define BRS_POR_DELAY_CYC      (((`BRS_POR_DELAY_US * 1000) + \
                                 `BRS_CLK_PERIOD_NS - 1) / `BRS_CLK_PERIOD_NS)
`define BRS_LINK_DEADLINE_MS   80
`define BRS_LINK_DEADLINE_CYC  ((`BRS_LINK_DEADLINE_MS * 1000000) / \
                                `BRS_CLK_PERIOD_NS)
`define BRS_LINK_MARGIN_CYC    4

`define BRS_SEC_BUS_CTL_OFS    8'h3E
`define BRS_SEC_BUS_CTL_RST    16'h0000
`define BRS_SECONDARY_RESET_CTL_BIT           6

`define BRS_PIN_SUPPLY         0
`define BRS_PIN_REFCLK         1
`define BRS_PIN_PERST          2
`define BRS_PIN_EEPROM         3
`define BRS_PIN_STRAP_LSB      4
`define BRS_PIN_STRAP_MSB      7
`define BRS_PIN_RST            8'h04

`endif

// >>> pkg/brs_pkg.sv
// Types of the bridge reset sequencer.
// Assumes brs_regs.svh for all numeric constants.
`default_nettype none
package brs_pkg;
  typedef enum logic [2:0] {
    ST_POWER,
    ST_REFCLK,
    ST_DELAY,
    ST_FUND,
    ST_LATCH,
    ST_EEPROM,
    ST_RUN,
    ST_DLDOWN
  } brs_state_type;

  typedef logic [7:0]  brs_pins_type;
  typedef logic [15:0] brs_word_type;
endpackage : brs_pkg
`default_nettype wire

// >>> pkg/brs_sync_if.sv
// Carrier between the sequencer and its pin synchroniser.
// Assumes both ends run on the same core clock.
`default_nettype none
interface brs_sync_if;
  brs_pkg::brs_pins_type raw;
  brs_pkg::brs_pins_type sync;
  logic                  release_n;

  modport sync_side (input raw, output sync, output release_n);
  modport core_side (output raw, input sync, input release_n);
endinterface : brs_sync_if
`default_nettype wire

// >>> core/brs_pin_sync.sv
// Two-flop synchronisers for the sequencer's pins and the release
// synchroniser for the combined asynchronous reset.
// Assumes arst_n_i asserts asynchronously; its release is retimed here.
`include "brs_regs.svh"
`default_nettype none
module brs_pin_sync (
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  input  wire logic pin_rst_n_i,
  input  wire logic ce_i,
  brs_sync_if.sync_side sif
);
  brs_pkg::brs_pins_type meta;
  logic [1:0]            rel;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      // First stage feeds the second stage only
      always_ff @(posedge ref_clk_i or negedge pin_rst_n_i) begin
        if (!pin_rst_n_i) begin
          meta[g]     <= 1'(`BRS_PIN_RST >> g);
          sif.sync[g] <= 1'(`BRS_PIN_RST >> g);
        end else if (ce_i) begin
          meta[g]     <= sif.raw[g];
          sif.sync[g] <= meta[g];
        end
      end
    end
  endgenerate

  // Assert at once, release two edges later to avoid recovery hazards
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rel <= 2'h0;
    end else if (ce_i) begin
      rel <= {rel[0], 1'b1};
    end
  end

  assign sif.release_n = rel[1];
endmodule : brs_pin_sync
`default_nettype wire

// >>> core/brs_reset_seq.sv
// Reset sequencer of a PCI Express to PCI bridge: power-on, global,
// fundamental and hot reset handling, strap latch and link start.
// Assumes pins are asynchronous and hot_reset_i comes from link logic.
`include "brs_regs.svh"
`default_nettype none
module brs_reset_seq #(
  parameter int unsigned LINK_DEADLINE_CYC = `BRS_LINK_DEADLINE_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        global_reset_n_i,
  input  wire logic        core_supply_sense_i,
  input  wire logic        refclk_active_i,
  input  wire logic        perst_n_i,
  input  wire logic        eeprom_present_i,
  input  wire logic [3:0]  strap_i,
  input  wire logic        hot_reset_i,
  input  wire logic        eeprom_done_i,
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [15:0] cfg_wdata_i,
  output logic      [15:0] cfg_rdata_o,
  output logic             rst_all_o,
  output logic             rst_nonsticky_o,
  output logic             rst_dl_o,
  output logic             secondary_bus_reset_n_o,
  output logic             power_good_o,
  output logic      [3:0]  strap_o,
  output logic             eeprom_start_o,
  output logic             link_train_o
);
  brs_sync_if              sif ();
  brs_pkg::brs_state_type  state;
  brs_pkg::brs_state_type  next_state;
  brs_pkg::brs_word_type   secondary_bus_control;
  logic                    arst_n;
  logic                    por_n;
  logic [10:0]             por_cnt;
  logic [23:0]             link_cnt;
  logic                    supply_ok;
  logic                    refclk_ok;
  logic                    perst_ok;
  logic                    por_src;
  logic                    fund_src;
  logic                    dl_src;
  logic                    any_src;
  logic                    ctl_hit;

  // Global reset joins the chip reset on the asynchronous path
  assign arst_n = rst_n_i & global_reset_n_i;

  assign sif.raw = {strap_i, eeprom_present_i, perst_n_i,
                    refclk_active_i, core_supply_sense_i};
  assign por_n   = sif.release_n;

  brs_pin_sync u_sync (
    .ref_clk_i   (ref_clk_i),
    .arst_n_i    (arst_n),
    .pin_rst_n_i (rst_n_i),
    .ce_i        (ce_i),
    .sif         (sif)
  );

  assign supply_ok = sif.sync[`BRS_PIN_SUPPLY];
  assign refclk_ok = sif.sync[`BRS_PIN_REFCLK];
  assign perst_ok  = sif.sync[`BRS_PIN_PERST];
  assign ctl_hit   = cfg_addr_i == `BRS_SEC_BUS_CTL_OFS;

  assign por_src  = (state == brs_pkg::ST_POWER) ||
                    (state == brs_pkg::ST_REFCLK) ||
                    (state == brs_pkg::ST_DELAY);
  assign fund_src = state == brs_pkg::ST_FUND;
  assign dl_src   = state == brs_pkg::ST_DLDOWN;
  assign any_src  = por_src || fund_src || dl_src ||
                    secondary_bus_control[`BRS_SECONDARY_RESET_CTL_BIT];

  always_comb begin
    next_state = state;
    case (state)
      brs_pkg::ST_POWER: begin
        if (supply_ok) next_state = brs_pkg::ST_REFCLK;
      end
      brs_pkg::ST_REFCLK: begin
        if (refclk_ok) next_state = brs_pkg::ST_DELAY;
      end
      brs_pkg::ST_DELAY: begin
        if (!refclk_ok) begin
          next_state = brs_pkg::ST_REFCLK;
        end else if (por_cnt == 11'(`BRS_POR_DELAY_CYC - 1)) begin
          next_state = brs_pkg::ST_FUND;
        end
      end
      brs_pkg::ST_FUND: begin
        if (perst_ok) next_state = brs_pkg::ST_LATCH;
      end
      brs_pkg::ST_LATCH: begin
        next_state = eeprom_present_i ? brs_pkg::ST_EEPROM
                                      : brs_pkg::ST_RUN;
      end
      brs_pkg::ST_EEPROM: begin
        // A stuck download must not delay training past the deadline
        if (eeprom_done_i ||
            link_cnt >= 24'(LINK_DEADLINE_CYC - `BRS_LINK_MARGIN_CYC)) begin
          next_state = brs_pkg::ST_RUN;
        end
      end
      brs_pkg::ST_RUN: begin
        if (hot_reset_i) next_state = brs_pkg::ST_DLDOWN;
      end
      brs_pkg::ST_DLDOWN: begin
        if (!hot_reset_i) next_state = brs_pkg::ST_RUN;
      end
      default: next_state = brs_pkg::ST_POWER;
    endcase
    // Losing supply restarts power-on; PERST low overrides later states
    if (!supply_ok) begin
      next_state = brs_pkg::ST_POWER;
    end else if (!perst_ok && !por_src) begin
      next_state = brs_pkg::ST_FUND;
    end
  end

  always_ff @(posedge ref_clk_i or negedge por_n) begin
    if (!por_n) begin
      state <= brs_pkg::ST_POWER;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk_i or negedge por_n) begin
    if (!por_n) begin
      por_cnt <= 11'h000;
    end else if (ce_i) begin
      por_cnt <= (state == brs_pkg::ST_DELAY) ? por_cnt + 11'h001
                                               : 11'h000;
    end
  end

  // Deadline counter runs from the release that started this bring-up
  always_ff @(posedge ref_clk_i or negedge por_n) begin
    if (!por_n) begin
      link_cnt <= 24'h000000;
    end else if (ce_i) begin
      if (por_src || fund_src) begin
        link_cnt <= 24'h000000;
      end else if (link_cnt != 24'hFFFFFF) begin
        link_cnt <= link_cnt + 24'h000001;
      end
    end
  end

  // Control register is not sticky: the power-on, fundamental and DL_DOWN sources clear it, ahead of any config write that loads it
  always_ff @(posedge ref_clk_i or negedge por_n) begin
    if (!por_n) begin
      secondary_bus_control <= `BRS_SEC_BUS_CTL_RST;
    end else if (ce_i) begin
      if (por_src || fund_src || dl_src) begin
        secondary_bus_control <= `BRS_SEC_BUS_CTL_RST;
      end else if (cfg_wr_i && ctl_hit) begin
        secondary_bus_control <= cfg_wdata_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge por_n) begin
    if (!por_n) begin
      cfg_rdata_o <= 16'h0000;
    end else if (ce_i && cfg_rd_i) begin
      cfg_rdata_o <= ctl_hit ? secondary_bus_control : 16'h0000;
    end
  end

  always_ff @(posedge ref_clk_i or negedge por_n) begin
    if (!por_n) begin
      rst_all_o               <= 1'b1;
      rst_nonsticky_o         <= 1'b1;
      rst_dl_o                <= 1'b1;
      secondary_bus_reset_n_o <= 1'b0;
    end else if (ce_i) begin
      rst_all_o               <= por_src;
      rst_nonsticky_o         <= por_src || fund_src;
      rst_dl_o                <= por_src || fund_src || dl_src;
      secondary_bus_reset_n_o <= !any_src;
    end
  end

  // Straps survive PERST and hot reset; only the chip or global reset (por_n) clears them
  always_ff @(posedge ref_clk_i or negedge por_n) begin
    if (!por_n) begin
      strap_o <= 4'h0;
    end else if (ce_i && state == brs_pkg::ST_LATCH) begin
      strap_o <= sif.sync[`BRS_PIN_STRAP_MSB:`BRS_PIN_STRAP_LSB];
    end
  end

  always_ff @(posedge ref_clk_i or negedge por_n) begin
    if (!por_n) begin
      power_good_o   <= 1'b0;
      eeprom_start_o <= 1'b0;
      link_train_o   <= 1'b0;
    end else if (ce_i) begin
      if (state == brs_pkg::ST_LATCH) begin
        power_good_o <= 1'b1;
      end else if (por_src || fund_src) begin
        power_good_o <= 1'b0;
      end
      eeprom_start_o <= (state == brs_pkg::ST_LATCH) &&
                        eeprom_present_i;
      link_train_o   <= state == brs_pkg::ST_RUN;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!por_n || !ce_i);

  sequence s_secondary_reset_ctl_set;
    cfg_wr_i && ctl_hit && cfg_wdata_i[`BRS_SECONDARY_RESET_CTL_BIT] && !any_src;
  endsequence

  sequence s_bit_held;
    secondary_bus_control[`BRS_SECONDARY_RESET_CTL_BIT] ##1 !secondary_bus_reset_n_o;
  endsequence

  a_supply_gate_hold: assert property (
    !supply_ok |=> state == brs_pkg::ST_POWER ##1 rst_all_o)
    else $error("power-on reset left before supply was good");

  a_refclk_delay_len: assert property (
    (state == brs_pkg::ST_FUND && $past(state) == brs_pkg::ST_DELAY)
      |-> por_cnt == 11'(`BRS_POR_DELAY_CYC))
    else $error("power-on release delay has the wrong length");

  a_por_clears_all: assert property (
    por_src |=> rst_all_o && rst_dl_o && secondary_bus_control == 16'h0000)
    else $error("power-on reset did not clear everything");

  a_src_drives_bus: assert property (
    (por_src || fund_src || dl_src) |=> !secondary_bus_reset_n_o)
    else $error("reset source did not assert the bus reset");

  a_strap_capture: assert property (
    state == brs_pkg::ST_LATCH
      |=> strap_o == $past(sif.sync[`BRS_PIN_STRAP_MSB:`BRS_PIN_STRAP_LSB]))
    else $error("straps not latched on reset release");

  a_train_deadline: assert property (
    state == brs_pkg::ST_EEPROM |-> link_cnt < 24'(LINK_DEADLINE_CYC))
    else $error("link training start passed its deadline");

  a_perst_fund_rst: assert property (
    (!perst_ok && supply_ok && !por_src)
      |=> fund_src ##1 (rst_nonsticky_o && !rst_all_o && !power_good_o))
    else $error("PERST low did not give a non-sticky reset");

  a_hot_dldown: assert property (
    (state == brs_pkg::ST_RUN && hot_reset_i && perst_ok && supply_ok)
      |=> dl_src ##1 (rst_dl_o && !rst_nonsticky_o))
    else $error("hot reset did not enter DL_DOWN");

  a_secondary_reset_ctl_bit_drive: assert property (
    s_secondary_reset_ctl_set |=> s_bit_held)
    else $error("control bit did not assert the bus reset");

  a_bus_release: assert property (
    !any_src |=> secondary_bus_reset_n_o)
    else $error("bus reset held without any source");
endmodule : brs_reset_seq
`default_nettype wire

// >>> tb/brs_host_model.sv
// Upstream system model: supply, reference clock, PERST, EEPROM done.
// Assumes the bench samples on the rising and drives on the falling edge.
`default_nettype none
module brs_host_model #(
  parameter int HOLD_CYC = 1400
) (
  input  wire logic clk_i,
  input  wire logic power_on_i,
  input  wire logic perst_req_i,
  input  wire logic eeprom_start_i,
  input  var  int   done_dly_i,
  output logic      supply_o,
  output logic      refclk_o,
  output logic      perst_n_o,
  output logic      eeprom_done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ok;
  initial begin
    supply_o = 1'b0;
    refclk_o = 1'b0;
    ok = 1'b0;
    eeprom_done_o = 1'b0;
  end
  // Scaled stand-in for the long hold times; must exceed the POR delay
  assign perst_n_o = ok && !perst_req_i;
  always begin
    wait (power_on_i);
    repeat (4) @(negedge clk_i);
    supply_o = 1'b1;
    repeat (4) @(negedge clk_i);
    refclk_o = 1'b1;
    repeat (HOLD_CYC) @(negedge clk_i);
    ok = 1'b1;
    wait (!power_on_i);
    ok = 1'b0;
    @(negedge clk_i) refclk_o = 1'b0;
    @(negedge clk_i) supply_o = 1'b0;
  end
  // Zero delay means the download never reports done
  always begin
    @(posedge clk_i iff eeprom_start_i === 1'b1);
    if (done_dly_i > 0) begin
      repeat (done_dly_i) @(negedge clk_i);
      eeprom_done_o = 1'b1;
      @(negedge clk_i) eeprom_done_o = 1'b0;
    end
  end
endmodule : brs_host_model
`default_nettype wire

// >>> tb/brs_reset_seq_tb.sv
// Self-checking bench of the reset sequencer with the host model.
// Assumes LINK_DEADLINE_CYC is cut to 64 for a short run.
`default_nettype none
module brs_reset_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] a; logic [15:0] d; logic [15:0] r; logic n;
  } brs_row_type;
  localparam brs_row_type ROWS [6] = '{
    '{8'h3E, 16'h0040, 16'h0040, 1'b0}, '{8'h3E, 16'h0000, 16'h0000, 1'b1},
    '{8'h3E, 16'hFFBF, 16'hFFBF, 1'b1}, '{8'h10, 16'h0040, 16'h0000, 1'b1},
    '{8'h3E, 16'hFFFF, 16'hFFFF, 1'b0}, '{8'h3E, 16'h0000, 16'h0000, 1'b1}};
  logic ref_clk = 1'b0, rst_n = 1'b0, glob_n = 1'b1, pwr = 1'b0;
  logic perst_req = 1'b0, ee_pres = 1'b1, hot = 1'b0;
  logic cfg_wr = 1'b0, cfg_rd = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [15:0] cfg_wdata = 16'h0000, rdata;
  logic [3:0] straps = 4'hA, strap_q;
  logic supply, refclk, perst_n, ee_done, ee_start, link;
  logic r_all, r_ns, r_dl, bus_n, pgood;
  int done_dly = 3, failures = 0, n_checks = 0, k;
  always #4 ref_clk = ~ref_clk;
  brs_host_model i_host (.clk_i(ref_clk), .power_on_i(pwr),
    .perst_req_i(perst_req), .eeprom_start_i(ee_start),
    .done_dly_i(done_dly), .supply_o(supply), .refclk_o(refclk),
    .perst_n_o(perst_n), .eeprom_done_o(ee_done));
  brs_reset_seq #(.LINK_DEADLINE_CYC(64)) i_dut (.ref_clk_i(ref_clk),
    .rst_n_i(rst_n), .ce_i(1'b1), .global_reset_n_i(glob_n),
    .core_supply_sense_i(supply), .refclk_active_i(refclk),
    .perst_n_i(perst_n), .eeprom_present_i(ee_pres), .strap_i(straps),
    .hot_reset_i(hot), .eeprom_done_i(ee_done), .cfg_wr_i(cfg_wr),
    .cfg_rd_i(cfg_rd), .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata),
    .cfg_rdata_o(rdata), .rst_all_o(r_all), .rst_nonsticky_o(r_ns),
    .rst_dl_o(r_dl), .secondary_bus_reset_n_o(bus_n),
    .power_good_o(pgood), .strap_o(strap_q), .eeprom_start_o(ee_start),
    .link_train_o(link));
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    cfg_addr = a;
    cfg_rd = 1'b1;
    cyc(1);
    cfg_rd = 1'b0;
    cyc(2);
  endtask : rd
  task end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // Bounded waits on the sequencer's own outputs
  task wait_link(input int n);
    for (k = 0; k < n && link !== 1'b1; k++) cyc(1);
  endtask : wait_link
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    end_sim();
  end
  initial begin
    cyc(5);
    chk("all", 1, r_all);
    chk("bus_n", 0, bus_n);
    rst_n = 1'b1;
    pwr = 1'b1;
    for (k = 0; k < 50 && refclk !== 1'b1; k++) cyc(1);
    cyc(1240);
    chk("all_hold", 1, r_all);
    cyc(25);
    chk("all_rel", 0, r_all);
    chk("ns_perst", 1, r_ns);
    wr(8'h3E, 16'h0040);
    for (k = 0; k < 300 && ee_start !== 1'b1; k++) cyc(1);
    chk("ee_start", 1, ee_start);
    chk("strap", 4'hA, strap_q);
    chk("pgood", 1, pgood);
    cyc(1);
    chk("ee_pulse", 0, ee_start);
    wait_link(64);
    chk("link", 1, link);
    chk("dl_run", 0, r_dl);
    rd(8'h3E);
    chk("refused", 0, rdata);
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a);
      chk("rdata", ROWS[i].r, rdata);
      chk("bus_row", ROWS[i].n, bus_n);
    end
    wr(8'h3E, 16'hFFBF);
    hot = 1'b1;
    cyc(3);
    chk("dl", 1, r_dl);
    chk("link_hot", 0, link);
    chk("ns_hot", 0, r_ns);
    chk("bus_hot", 0, bus_n);
    hot = 1'b0;
    wait_link(8);
    rd(8'h3E);
    chk("hot_clr", 0, rdata);
    chk("bus_back", 1, bus_n);
    done_dly = 0;
    perst_req = 1'b1;
    cyc(4);
    chk("ns", 1, r_ns);
    chk("all_p", 0, r_all);
    chk("pg_low", 0, pgood);
    chk("bus_p", 0, bus_n);
    perst_req = 1'b0;
    cyc(4);
    wait_link(70);
    chk("deadline", 1, link);
    straps = 4'h5;
    done_dly = 2;
    @(negedge ref_clk) glob_n = 1'b0;
    #1;
    chk("glob_all", 1, r_all);
    chk("glob_bus", 0, bus_n);
    cyc(3);
    glob_n = 1'b1;
    wait_link(1400);
    chk("glob_link", 1, link);
    chk("strap2", 4'h5, strap_q);
    pwr = 1'b0;
    for (k = 0; k < 10 && r_all !== 1'b1; k++) cyc(1);
    chk("pwr_off", 1, r_all);
    end_sim();
  end
endmodule : brs_reset_seq_tb
`default_nettype wire
